// ==== src/counter_status_feedback.sv ====
// Purpose: Sticky status, live status and error feedback of a counter
// Assumes: Event inputs come from the counting core on pclk
// Notes: aux_input and supply_short are pins and are synchronised
////////////////////////////////////////////////////////////////////////////
//
// The register offsets and register access over APB were left to the implementer.
module counter_status_feedback
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Counting core events and levels
   input wire logic sync_evt,
   input wire logic upper_evt,
   input wire logic lower_evt,
   input wire logic zero_evt,
   input wire logic count_step,
   input wire logic count_up,
   input wire logic gate_in,
   input wire logic bus_tick,
   input wire logic master_stop,
   input wire logic param_ok,
   input wire logic param_bad,
   // Pins
   input wire logic aux_input,
   input wire logic supply_short,
   // Load path to counting core
   output logic load_strobe,
   output logic [4:0] load_target,
   output logic [31:0] load_data,
   // Feedback
   output fb_pkg::feedback_t feedback,
   output logic channel_diag
);
   import fb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Latency helpers
   function automatic logic [2:0] lat_step(input logic iso,
                                           input logic tick);
      lat_step = iso ? {2'h0, tick} : 3'h1;
   endfunction : lat_step

   function automatic logic [2:0] lat_target(input logic iso,
                                             input logic six);
      lat_target = iso ? (six ? ISO_LONG_CYCLES : ISO_SHORT_CYCLES)
                       : PLAIN_CYCLES;
   endfunction : lat_target

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   ctrl_t ctrl_reg, ctrl_next;             // Control register
   logic [4:0] req_reg, req_next;          // Load request bits
   logic [31:0] val_reg, val_next;         // Load value
   logic [31:0] prdata_reg, prdata_next;   // Read data
   logic err_reg, err_next;                // Bus error
   logic [2:0] aux_s, aux_s_next;          // Aux pin synchroniser
   logic [2:0] sup_s, sup_s_next;          // Supply pin synchroniser
   logic aux_reg, aux_next;                // Filtered aux level
   logic short_reg, short_next;            // Filtered supply short
   feedback_t fb_reg, fb_next;             // Flags and status
   clear_state_t cst_reg, cst_next;        // Clear handshake
   logic [2:0] ccnt_reg, ccnt_next;        // Clear latency count
   load_state_t lst_reg, lst_next;         // Load handshake
   logic [2:0] lcnt_reg, lcnt_next;        // Load latency count
   logic strobe_next;
   logic [4:0] target_next;
   logic [31:0] data_next;
   logic setup, access, clr_pulse, conflict, one_hot;
   logic good_load, bad_load, transparent;

   ////////////////////////////////////////////////////////////////////////
   // APB decode: read data taken in setup, zero wait access
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign pready = access;
   assign prdata = prdata_reg;
   assign pslverr = err_reg && access;
   assign feedback = fb_reg;

   always_comb
   begin
      ctrl_next = ctrl_reg;
      req_next = req_reg;
      val_next = val_reg;
      prdata_next = prdata_reg;
      err_next = err_reg;
      // Setup phase: decode and prepare answer
      if (setup)
      begin
         err_next = 1'b0;
         case (paddr)
            CTRL_OFS: prdata_next = {26'h0, ctrl_reg};
            LOADREQ_OFS: prdata_next = {27'h0, req_reg};
            LOADVAL_OFS: prdata_next = val_reg;
            STATUS_OFS: prdata_next = {19'h0, fb_reg};
            default:
            begin
               prdata_next = 32'h00000000;
               err_next = 1'b1;
            end
         endcase
      end
      // Access phase: write takes effect
      if (access && pwrite)
      begin
         case (paddr)
            CTRL_OFS: ctrl_next = ctrl_t'(pwdata[CTRL_WIDTH-1:0]);
            LOADREQ_OFS: req_next = pwdata[REQ_WIDTH-1:0];
            LOADVAL_OFS: val_next = pwdata;
            default: ; // Status read only, unmapped ignored
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= ctrl_t'(CTRL_RESET);
         req_reg <= REQ_RESET;
         val_reg <= LOADVAL_RESET;
         prdata_reg <= 32'h00000000;
         err_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         req_reg <= req_next;
         val_reg <= val_next;
         prdata_reg <= prdata_next;
         err_reg <= err_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: change counts when stages two and three agree
   always_comb
   begin
      aux_s_next = {aux_s[1:0], aux_input};
      sup_s_next = {sup_s[1:0], supply_short};
      aux_next = (aux_s[1] == aux_s[2]) ? aux_s[2] : aux_reg;
      short_next = (sup_s[1] == sup_s[2]) ? sup_s[2] : short_reg;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         aux_s <= 3'h0;
         sup_s <= 3'h0;
         aux_reg <= 1'b0;
         short_reg <= 1'b0;
      end
      else
      begin
         aux_s <= aux_s_next;
         sup_s <= sup_s_next;
         aux_reg <= aux_next;
         short_reg <= short_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag clear handshake and load handshake
   assign conflict = !$onehot0(req_reg);
   assign one_hot = $onehot(req_reg);
   assign clr_pulse = (cst_reg == C_WAIT) && (cst_next == C_ACTIVE);

   always_comb
   begin
      cst_next = cst_reg;
      ccnt_next = ccnt_reg;
      lst_next = lst_reg;
      lcnt_next = lcnt_reg;
      strobe_next = 1'b0;
      target_next = load_target;
      data_next = load_data;
      good_load = 1'b0;
      bad_load = 1'b0;
      // Status reset: request, latency, clear, acknowledge
      case (cst_reg)
         C_IDLE:
         begin
            ccnt_next = 3'h0;
            if (ctrl_reg.flag_clear_request)
               cst_next = C_WAIT;
         end
         C_WAIT:
         begin
            ccnt_next = ccnt_reg + lat_step(ctrl_reg.iso_mode, bus_tick);
            if (!ctrl_reg.flag_clear_request)
               cst_next = C_IDLE;
            else if (ccnt_next >= lat_target(ctrl_reg.iso_mode,
                                             ctrl_reg.iso_six))
               cst_next = C_ACTIVE;
         end
         C_ACTIVE:
            if (!ctrl_reg.flag_clear_request)
               cst_next = C_IDLE;
         default: cst_next = C_IDLE;
      endcase
      // Load: one request bit, latency, check and apply
      case (lst_reg)
         L_IDLE:
         begin
            lcnt_next = 3'h0;
            if (one_hot)
               lst_next = L_WAIT;
         end
         L_WAIT:
         begin
            lcnt_next = lcnt_reg + lat_step(ctrl_reg.iso_mode, bus_tick);
            if (!one_hot)
               lst_next = L_IDLE;
            else if (lcnt_next >= lat_target(ctrl_reg.iso_mode,
                                             ctrl_reg.iso_six))
            begin
               lst_next = L_DONE;
               // Count loads are range checked, old value kept on fault
               if (req_reg[1:0] != 2'h0 &&
                   ($signed(val_reg) > COUNT_MAX ||
                    $signed(val_reg) < COUNT_MIN))
                  bad_load = 1'b1;
               else
               begin
                  good_load = 1'b1;
                  strobe_next = 1'b1;
                  target_next = req_reg;
                  data_next = val_reg;
               end
            end
         end
         L_DONE:
            if (req_reg == 5'h00)
               lst_next = L_IDLE;
         default: lst_next = L_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cst_reg <= C_IDLE;
         ccnt_reg <= 3'h0;
         lst_reg <= L_IDLE;
         lcnt_reg <= 3'h0;
         load_strobe <= 1'b0;
         load_target <= 5'h00;
         load_data <= 32'h00000000;
      end
      else
      begin
         cst_reg <= cst_next;
         ccnt_reg <= ccnt_next;
         lst_reg <= lst_next;
         lcnt_reg <= lcnt_next;
         load_strobe <= strobe_next;
         load_target <= target_next;
         load_data <= data_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky flags, live status and errors
   assign transparent = ctrl_reg.error_acknowledge || master_stop;

   always_comb
   begin
      fb_next = fb_reg;
      // Sticky events, set wins over clear
      fb_next.sync_done_flag = sync_evt ||
         (fb_reg.sync_done_flag && !clr_pulse);
      fb_next.upper_limit_flag = upper_evt ||
         (fb_reg.upper_limit_flag && !clr_pulse);
      fb_next.lower_limit_flag = lower_evt ||
         (fb_reg.lower_limit_flag && !clr_pulse);
      fb_next.zero_cross_flag = (zero_evt && ctrl_reg.free_direction) ||
         (fb_reg.zero_cross_flag && !clr_pulse);
      fb_next.flag_clear_active = (cst_next == C_ACTIVE);
      fb_next.aux_input_level = aux_reg;
      fb_next.gate_open = gate_in;
      fb_next.load_busy = (lst_next == L_WAIT);
      // Direction of the last count change
      if (count_step)
      begin
         fb_next.counting_upward = count_up;
         fb_next.counting_downward = !count_up;
      end
      // Errors follow cause when transparent, else latch (load error until a good load)
      if (transparent)
      begin
         fb_next.supply_fault_error = short_reg;
         fb_next.load_error = conflict || bad_load;
      end
      else
      begin
         fb_next.supply_fault_error = short_reg ||
            fb_reg.supply_fault_error;
         fb_next.load_error = conflict || bad_load ||
            (fb_reg.load_error && !good_load);
      end
      // Only correct parameters clear this one
      fb_next.parameter_error = param_bad ||
         (fb_reg.parameter_error && !param_ok);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fb_reg <= feedback_t'(13'h0000);
         channel_diag <= 1'b0;
      end
      else
      begin
         fb_reg <= fb_next;
         channel_diag <= ctrl_reg.group_diag_enable &&
            (fb_next.supply_fault_error || fb_next.load_error ||
             fb_next.parameter_error);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sync_set_a: assert property (sync_evt |=> fb_reg.sync_done_flag)
      else $error("sync event lost");
   flag_clear_a: assert property (
      $rose(fb_reg.flag_clear_active) && !$past(sync_evt)
      |-> !fb_reg.sync_done_flag)
      else $error("sync flag not cleared by handshake");
   conflict_err_a: assert property (conflict |=> fb_reg.load_error)
      else $error("conflict without load error");
   bad_load_a: assert property (
      bad_load |=> fb_reg.load_error && !load_strobe)
      else $error("invalid load value accepted");
   supply_hold_a: assert property (
      fb_reg.supply_fault_error && !transparent
      |=> fb_reg.supply_fault_error)
      else $error("supply fault dropped without acknowledge");
   transparent_a: assert property (
      transparent && !short_reg |=> !fb_reg.supply_fault_error)
      else $error("supply fault not cleared when transparent");
   param_keep_a: assert property (
      fb_reg.parameter_error && !param_ok |=> fb_reg.parameter_error)
      else $error("parameter error cleared wrongly");
   iso_lat_a: assert property (
      $rose(fb_reg.flag_clear_active) && ctrl_reg.iso_mode &&
      $stable(ctrl_reg) |-> ccnt_reg == (ctrl_reg.iso_six ? 3'h6 : 3'h4))
      else $error("isochronous latency wrong");
   aux_level_a: assert property (
      aux_s[1] == aux_s[2]
      |=> ##1 fb_reg.aux_input_level == $past(aux_s[2], 2))
      else $error("aux level not reported");
   clear_done_c: cover property ($fell(fb_reg.flag_clear_active));
   load_done_c: cover property (load_strobe);
   conflict_c: cover property (conflict ##1 one_hot);
endmodule : counter_status_feedback

// ==== inc/fb_pkg.sv ====
// Purpose: Shared constants and types of the counter status feedback block
// Assumes: APB register access, 32-bit data, one clock
// Notes: Offsets are byte addresses of aligned words
package fb_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] LOADREQ_OFS = 8'h04;
   localparam logic [7:0] LOADVAL_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   // Control register field positions
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int CTRL_ACK_BIT = 1;
   localparam int CTRL_DIAG_BIT = 2;
   localparam int CTRL_ISO_BIT = 3;
   localparam int CTRL_SIX_BIT = 4;
   localparam int CTRL_FREE_BIT = 5;
   localparam int CTRL_WIDTH = 6;
   localparam int REQ_WIDTH = 5;
   localparam int STATUS_WIDTH = 13;
   // Reset values
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [4:0] REQ_RESET = 5'h00;
   localparam logic [31:0] LOADVAL_RESET = 32'h00000000;
   // Latency in bus cycles (isochronous) or clock cycles (otherwise)
   localparam logic [2:0] ISO_SHORT_CYCLES = 3'h4;
   localparam logic [2:0] ISO_LONG_CYCLES = 3'h6;
   localparam logic [2:0] PLAIN_CYCLES = 3'h1;
   // Accepted range of a count load value
   localparam logic signed [31:0] COUNT_MAX = 32'sh7FFFFFFF;
   localparam logic signed [31:0] COUNT_MIN = -32'sh7FFFFFFF;
   // Control register image
   typedef struct packed {
      logic free_direction;    // Counting without main direction
      logic iso_six;           // Isochronous latency of 6, else 4
      logic iso_mode;          // Isochronous operation
      logic group_diag_enable; // Diagnostics enabled
      logic error_acknowledge; // Error acknowledge
      logic flag_clear_request; // Sticky flag reset request
   } ctrl_t;
   // Feedback image
   typedef struct packed {
      logic parameter_error;
      logic load_error;
      logic supply_fault_error;
      logic counting_downward;
      logic counting_upward;
      logic load_busy;
      logic gate_open;
      logic aux_input_level;
      logic flag_clear_active;
      logic zero_cross_flag;
      logic lower_limit_flag;
      logic upper_limit_flag;
      logic sync_done_flag;
   } feedback_t;
   // Flag clear handshake states
   typedef enum logic [1:0] {C_IDLE, C_WAIT, C_ACTIVE} clear_state_t;
   // Load handshake states
   typedef enum logic [1:0] {L_IDLE, L_WAIT, L_DONE} load_state_t;
endpackage : fb_pkg

// ==== sim/fb_master_model.sv ====
// Purpose: Bus master stand-in that writes control and reads feedback
// Assumes: APB, pready sampled at rising edges
// Notes: Signals change only just after a rising edge
module fb_master_model
(
   // Clock and answer
   input wire logic pclk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   // One transfer, held until pready is seen at a rising edge
   task automatic bus_xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : bus_xfer
endmodule : fb_master_model

// ==== sim/counter_status_feedback_tb_top.sv ====
// Purpose: Self-checking bench of the counter status feedback block
// Assumes: Model drives APB, bench drives core events and pins
// Notes: Pins pass a 3-stage synchroniser, waits allow for it
module counter_status_feedback_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fb_pkg::*;
   logic pclk, presetn, err, busy_seen;
   wire psel, penable, pwrite, pready, pslverr;
   wire [7:0] paddr;
   wire [31:0] pwdata, prdata;
   logic sync_evt, upper_evt, lower_evt, zero_evt, count_step, count_up;
   logic gate_in, bus_tick, master_stop, param_ok, param_bad;
   logic aux_input, supply_short, load_strobe, channel_diag;
   logic [4:0] load_target;
   logic [31:0] load_data, last_data, rd;
   feedback_t feedback;
   int failures = 0;
   int n_checks = 0;
   int strobes = 0;
   ////////////////////////////////////////////////////////////////////////
   // Design and master
   counter_status_feedback i_counter_status_feedback
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sync_evt, .upper_evt, .lower_evt,
      .zero_evt, .count_step, .count_up, .gate_in, .bus_tick,
      .master_stop, .param_ok, .param_bad, .aux_input, .supply_short,
      .load_strobe, .load_target, .load_data, .feedback, .channel_diag
   );
   fb_master_model i_fb_master_model
   (
      .pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite,
      .paddr, .pwdata
   );
   // 50 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // Count accepted loads, note a busy phase
   always @(posedge pclk)
   begin
      if (load_strobe === 1'b1)
      begin
         strobes <= strobes + 1;
         last_data <= load_data;
      end
      if (feedback.load_busy === 1'b1)
         busy_seen <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_fb_master_model.bus_xfer(1'b1, a, d, rd, err);
   endtask : wr
   task automatic rdw(input logic [7:0] a);
      i_fb_master_model.bus_xfer(1'b0, a, 32'h00000000, rd, err);
   endtask : rdw
   // Wait edges, then sample at the falling edge
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : wait_cyc
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge pclk);
         bus_tick <= 1'b1;
         @(posedge pclk);
         bus_tick <= 1'b0;
      end
   endtask : tick
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdw(CTRL_OFS);
      check("ctrl reset", rd, 32'h00000000);
      rdw(STATUS_OFS);
      check("status reset", rd, 32'h00000000);
      rdw(8'h10);
      check("unmapped err", {31'h0, err}, 32'h00000001);
      check("unmapped data", rd, 32'h00000000);
      $display("test reset done");
   endtask : t_reset
   task automatic t_sticky;
      wr(CTRL_OFS, 32'h00000020);
      @(posedge pclk);
      {sync_evt, upper_evt, lower_evt, zero_evt} <= 4'hF;
      @(posedge pclk);
      {sync_evt, upper_evt, lower_evt, zero_evt} <= 4'h0;
      wait_cyc(4);
      rdw(STATUS_OFS);
      check("sticky flags", rd[3:0], 32'h0000000F);
      wr(CTRL_OFS, 32'h00000021);
      // Event lands on the very edge at which the flags are cleared
      @(posedge pclk);
      upper_evt <= 1'b1;
      @(posedge pclk);
      upper_evt <= 1'b0;
      wait_cyc(2);
      check("clear active", feedback.flag_clear_active, 32'h1);
      check("flags cleared", feedback[3:0], 32'h2);
      check("event wins", feedback.upper_limit_flag, 32'h1);
      wr(CTRL_OFS, 32'h00000020);
      wait_cyc(2);
      check("clear done", feedback.flag_clear_active, 32'h0);
      $display("test sticky done");
   endtask : t_sticky
   task automatic t_iso;
      for (int i = 0; i < 2; i++)
      begin
         wr(CTRL_OFS, i ? 32'h00000019 : 32'h00000009);
         wait_cyc(1);
         tick(i ? 5 : 3);
         wait_cyc(3);
         check("iso early", feedback.flag_clear_active, 32'h0);
         tick(1);
         wait_cyc(3);
         check("iso on time", feedback.flag_clear_active, 32'h1);
         wr(CTRL_OFS, 32'h00000000);
         wait_cyc(2);
      end
      $display("test iso done");
   endtask : t_iso
   task automatic t_load;
      wr(LOADVAL_OFS, 32'h00000005);
      wr(LOADREQ_OFS, 32'h00000003);
      wait_cyc(7);
      check("conflict err", feedback.load_error, 32'h1);
      check("conflict no load", strobes, 32'h0);
      wr(LOADREQ_OFS, 32'h00000000);
      wait_cyc(3);
      check("error kept", feedback.load_error, 32'h1);
      for (int i = 0; i < 5; i++)
      begin
         busy_seen = 1'b0;
         wr(LOADREQ_OFS, 32'h00000001 << i);
         wait_cyc(5);
         check("load count", strobes, i + 1);
         check("load target", load_target, 32'h00000001 << i);
         check("load busy", busy_seen, 32'h1);
         check("load value", last_data, 32'h00000005);
         check("error cleared", feedback.load_error, 32'h0);
         wr(LOADREQ_OFS, 32'h00000000);
      end
      wr(LOADVAL_OFS, 32'h80000000);
      wr(LOADREQ_OFS, 32'h00000001);
      wait_cyc(5);
      check("bad value err", feedback.load_error, 32'h1);
      check("bad value skip", strobes, 32'h5);
      check("old value kept", load_data, 32'h00000005);
      wr(LOADREQ_OFS, 32'h00000000);
      $display("test load done");
   endtask : t_load
   task automatic t_errors;
      // Acknowledge held drops the load error left by the load test
      wr(CTRL_OFS, 32'h00000002);
      wr(CTRL_OFS, 32'h00000004);
      wait_cyc(1);
      check("diag idle", channel_diag, 32'h0);
      @(posedge pclk);
      supply_short <= 1'b1;
      wait_cyc(6);
      check("supply err", feedback.supply_fault_error, 32'h1);
      check("diag on", channel_diag, 32'h1);
      @(posedge pclk);
      supply_short <= 1'b0;
      wait_cyc(6);
      check("supply sticky", feedback.supply_fault_error, 32'h1);
      wr(CTRL_OFS, 32'h00000006);
      wait_cyc(3);
      check("supply acked", feedback.supply_fault_error, 32'h0);
      check("diag off", channel_diag, 32'h0);
      @(posedge pclk);
      param_bad <= 1'b1;
      @(posedge pclk);
      param_bad <= 1'b0;
      wait_cyc(3);
      check("param err", feedback.parameter_error, 32'h1);
      @(posedge pclk);
      param_ok <= 1'b1;
      @(posedge pclk);
      param_ok <= 1'b0;
      wait_cyc(3);
      check("param ok", feedback.parameter_error, 32'h0);
      wr(CTRL_OFS, 32'h00000000);
      @(posedge pclk);
      master_stop <= 1'b1;
      supply_short <= 1'b1;
      wait_cyc(6);
      check("stop shows err", feedback.supply_fault_error, 32'h1);
      check("diag disabled", channel_diag, 32'h0);
      @(posedge pclk);
      supply_short <= 1'b0;
      wait_cyc(6);
      check("stop clears", feedback.supply_fault_error, 32'h0);
      @(posedge pclk);
      master_stop <= 1'b0;
      $display("test errors done");
   endtask : t_errors
   task automatic t_live(input logic lvl);
      @(posedge pclk);
      aux_input <= lvl;
      gate_in <= lvl;
      count_up <= lvl;
      count_step <= 1'b1;
      @(posedge pclk);
      count_step <= 1'b0;
      wait_cyc(5);
      check("aux level", feedback.aux_input_level, lvl);
      check("gate open", feedback.gate_open, lvl);
      check("direction", feedback[9:8], lvl ? 2'h1 : 2'h2);
      $display("test live done");
   endtask : t_live
   ////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   // Main sequence
   initial
   begin
      presetn = 1'b0;
      {sync_evt, upper_evt, lower_evt, zero_evt, count_step} = '0;
      {count_up, gate_in, bus_tick, master_stop, param_ok} = '0;
      {param_bad, aux_input, supply_short, busy_seen} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_sticky();
      t_iso();
      t_load();
      t_errors();
      t_live(1'b1);
      t_live(1'b0);
      results();
   end
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge pclk);
      failures++;
      $display("MISMATCH watchdog expected end seen timeout");
      results();
   end
endmodule : counter_status_feedback_tb_top
